// ==== cabo_core.sv ====
// Execution slice with a Wishbone slave, quarter-phase sequencer and data memory.
//
// The register offsets and the Wishbone interface to the registers were left to the implementer.
`timescale 1ns/1ps
// Contract
// - Add sums working, carry and file register
// - Add updates negative, overflow, carry, digit, zero
// - Destination bit zero writes working register
// - Access bit zero picks access bank
// - Extended set indexes offsets up to 5Fh
// - AND literal into working, N and Z
// - AND file to destination, N and Z
// - Bit clear touches one bit only
// - Taken branch adds twice offset to PC
// - Branch on carry when carry set
// - Branch on no carry when clear
// - Branch on negative when negative set
// - Branch on not negative when clear
// - Branch one cycle, two when taken
module cabo_core import cabo_pkg::*; #(
	parameter int DM_AW = 12 // Data memory address width, at most 12.
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	output logic busy_o
);

	localparam int DM_DEPTH = 1 << DM_AW;

	// Every piece of state lives in this one record.
	typedef struct packed {
		cabo_state_type fsm;         // Quarter-phase sequencer.
		logic [1:0] nop_cnt;         // Quarter within the idle branch cycle.
		logic ack;                   // Bus acknowledge.
		logic busy;                  // Instruction in flight.
		logic [31:0] dat;            // Bus read data.
		logic ext;                   // Extended instruction set enabled.
		logic [15:0] ir;             // Instruction word.
		cabo_op_type op;             // Decoded class.
		logic [7:0] w;               // Working register.
		logic [4:0] status;          // Flags.
		logic [3:0] bank;            // Bank select register.
		logic [20:0] pc;             // Program counter.
		logic [11:0] idx;            // Indexed offset base.
		logic [11:0] maddr;          // Memory window address.
		logic [DM_AW-1:0] ea;        // Effective file address.
		logic [7:0] opnd;            // Operand read in the second quarter.
		logic [7:0] res;             // Result formed in the third quarter.
		logic [4:0] flg;             // Flags formed in the third quarter.
		logic taken;                 // Branch condition met.
		logic [DM_DEPTH-1:0][7:0] mem; // File registers.
	} cabo_st_type;

	cabo_st_type q;
	cabo_st_type d;
	logic [7:0] alu_res;
	logic [4:0] alu_flg;

	////////////////////////////////////////////////////////////////////////////////
	// Helpers.

	// Classifies an instruction word; unknown words run as a plain cycle.
	function automatic cabo_op_type op_decode(input logic [15:0] ir);
		cabo_op_type r;
		r = OP_NONE;
		if (ir[15:10] == OPC_ADDC) begin
			r = OP_ADD;
		end else if (ir[15:8] == OPC_ANDL) begin
			r = OP_ANDL;
		end else if (ir[15:10] == OPC_ANDF) begin
			r = OP_ANDF;
		end else if (ir[15:12] == OPC_BCLR) begin
			r = OP_BCLR;
		end else if (ir[15:8] == OPC_BRC || ir[15:8] == OPC_BRNC ||
				ir[15:8] == OPC_BRN || ir[15:8] == OPC_BRNN) begin
			r = OP_BR;
		end
		return r;
	endfunction

	// Condition of the four branches on carry and negative.
	function automatic logic br_cond(input logic [15:0] ir, input logic [4:0] st);
		logic r;
		case (ir[15:8])
			OPC_BRC: r = st[FLG_C];
			OPC_BRNC: r = !st[FLG_C];
			OPC_BRN: r = st[FLG_N];
			OPC_BRNN: r = !st[FLG_N];
			default: r = 1'b0;
		endcase
		return r;
	endfunction

	// Effective address of a file operand.
	function automatic logic [11:0] ea_calc(input logic [15:0] ir, input logic ext,
			input logic [3:0] bank, input logic [11:0] idx);
		logic [11:0] r;
		if (ir[ACC_BIT]) begin
			r = {bank, ir[7:0]};
		end else if (ext && ir[7:0] <= IDX_LIMIT) begin
			r = idx + {4'h0, ir[7:0]};
		end else if (ir[7:0] <= IDX_LIMIT) begin
			r = {4'h0, ir[7:0]};
		end else begin
			r = {ACC_HI_BANK, ir[7:0]};
		end
		return r;
	endfunction

	// Byte-lane merge of a bus write into an old value.
	function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] nw,
			input logic [3:0] sel);
		logic [31:0] r;
		for (int i = 0; i < 4; i++) begin
			r[8*i +: 8] = sel[i] ? nw[8*i +: 8] : old[8*i +: 8];
		end
		return r;
	endfunction

	// Branch offset doubled and sign-extended to the counter width.
	function automatic logic [20:0] br_off(input logic [7:0] n);
		return {{12{n[7]}}, n, 1'b0};
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Data path.
	cabo_alu cabo_alu_inst (
		.op_i(q.op),
		.acc_i(q.w),
		.opnd_i(q.opnd),
		.cin_i(q.status[FLG_C]),
		.bsel_i(q.ir[11:9]),
		.res_o(alu_res),
		.flg_o(alu_flg)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Next state: bus slave and sequencer.
	// The bus is served only while idle, so software never races the sequencer.
	always_comb begin
		logic [31:0] wv;
		wv = 32'h0;
		d = q;
		d.ack = 1'b0;
		if (wb_cyc_i && wb_stb_i && !q.ack && q.fsm == S_IDLE) begin
			d.ack = 1'b1;
			d.dat = 32'h0; // Unmapped offsets read zero and ignore writes.
			case (wb_adr_i)
				REG_CTRL: d.dat = {31'h0, q.ext};
				REG_INSTR: d.dat = {16'h0, q.ir};
				REG_WACC: d.dat = {24'h0, q.w};
				REG_STATUS: d.dat = {27'h0, q.status};
				REG_BANK: d.dat = {28'h0, q.bank};
				REG_PC: d.dat = {11'h0, q.pc};
				REG_IDX: d.dat = {20'h0, q.idx};
				REG_MADDR: d.dat = {20'h0, q.maddr};
				REG_MDATA: d.dat = {24'h0, q.mem[q.maddr[DM_AW-1:0]]};
				REG_STATE: d.dat = {24'h0, q.taken, q.busy, q.fsm};
				default: d.dat = 32'h0;
			endcase
			if (wb_we_i) begin
				wv = wmerge(d.dat, wb_dat_i, wb_sel_i);
				case (wb_adr_i)
					REG_CTRL: d.ext = wv[CTRL_EXT];
					REG_INSTR: begin
						d.ir = wv[15:0];
						d.fsm = S_Q1; // A write launches the instruction.
					end
					REG_WACC: d.w = wv[7:0];
					REG_STATUS: d.status = wv[4:0];
					REG_BANK: d.bank = wv[3:0];
					REG_PC: d.pc = wv[20:0];
					REG_IDX: d.idx = wv[11:0];
					REG_MADDR: d.maddr = wv[11:0];
					REG_MDATA: d.mem[q.maddr[DM_AW-1:0]] = wv[7:0];
					default: d.ext = q.ext;
				endcase
			end
		end
		case (q.fsm)
			S_IDLE: begin
				d.taken = q.taken;
			end
			S_Q1: begin
				// Decode; the counter moves past this word as it is fetched.
				d.op = op_decode(q.ir);
				d.pc = q.pc + PC_STEP;
				d.ea = DM_AW'(ea_calc(q.ir, q.ext, q.bank, q.idx));
				d.taken = 1'b0;
				d.fsm = S_Q2;
			end
			S_Q2: begin
				// Read the literal or the file register.
				if (q.op == OP_ANDL || q.op == OP_BR) begin
					d.opnd = q.ir[7:0];
				end else begin
					d.opnd = q.mem[q.ea];
				end
				d.fsm = S_Q3;
			end
			S_Q3: begin
				d.res = alu_res;
				d.flg = alu_flg;
				d.taken = (q.op == OP_BR) && br_cond(q.ir, q.status);
				d.fsm = S_Q4;
			end
			S_Q4: begin
				d.fsm = S_IDLE;
				case (q.op)
					OP_ADD, OP_ANDF: begin
						if (q.ir[DEST_BIT]) begin
							d.mem[q.ea] = q.res;
						end else begin
							d.w = q.res;
						end
						if (q.op == OP_ADD) begin
							d.status = q.flg;
						end else begin
							d.status[FLG_N] = q.flg[FLG_N];
							d.status[FLG_Z] = q.flg[FLG_Z];
						end
					end
					OP_ANDL: begin
						d.w = q.res;
						d.status[FLG_N] = q.flg[FLG_N];
						d.status[FLG_Z] = q.flg[FLG_Z];
					end
					OP_BCLR: begin
						d.mem[q.ea] = q.res;
					end
					OP_BR: begin
						if (q.taken) begin
							d.pc = q.pc + br_off(q.opnd);
							d.nop_cnt = 2'h0;
							d.fsm = S_NOP;
						end
					end
					default: begin
						d.fsm = S_IDLE;
					end
				endcase
			end
			S_NOP: begin
				// Second cycle of a taken branch does nothing for four quarters.
				d.nop_cnt = q.nop_cnt + 2'h1;
				if (q.nop_cnt == NOP_LAST) begin
					d.fsm = S_IDLE;
				end
			end
			default: begin
				d.fsm = S_IDLE;
			end
		endcase
		d.busy = (d.fsm != S_IDLE);
	end

	////////////////////////////////////////////////////////////////////////////////
	// State register.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			q <= '0;
			q.fsm <= S_IDLE;
			q.w <= RST_WACC;
			q.status <= RST_STATUS;
			q.bank <= RST_BANK;
			q.pc <= RST_PC;
			q.ext <= RST_EXT;
		end else begin
			q <= d;
		end
	end

	assign wb_dat_o = q.dat;
	assign wb_ack_o = q.ack;
	assign busy_o = q.busy;

	////////////////////////////////////////////////////////////////////////////////
	// Checks.
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	property p_add_sum;
		(q.fsm == S_Q4 && q.op == OP_ADD) |->
			q.res == 8'(q.w + q.opnd + {7'h0, q.status[FLG_C]});
	endproperty
	a_add_sum: assert property (p_add_sum) else $error("add result wrong");

	property p_add_flags;
		(q.fsm == S_Q4 && q.op == OP_ADD) |=>
			q.status[FLG_Z] == ($past(q.res) == 8'h00) && q.status[FLG_N] == $past(q.res[7]);
	endproperty
	a_add_flags: assert property (p_add_flags) else $error("add flags wrong");

	property p_dest_w;
		(q.fsm == S_Q4 && (q.op == OP_ADD || q.op == OP_ANDF) && !q.ir[DEST_BIT])
			|=> q.w == $past(q.res);
	endproperty
	a_dest_w: assert property (p_dest_w) else $error("result missed W");

	property p_andl;
		(q.fsm == S_Q1 && q.ir[15:8] == OPC_ANDL) |=> ##3
			q.w == ($past(q.w, 4) & $past(q.ir[7:0], 4)) && q.status[FLG_C] == $past(q.status[FLG_C], 4);
	endproperty
	a_andl: assert property (p_andl) else $error("AND literal wrong");

	property p_bclr_flags;
		(q.fsm == S_Q1 && q.ir[15:12] == OPC_BCLR) |=> $stable(q.status)[*4];
	endproperty
	a_bclr_flags: assert property (p_bclr_flags) else $error("bit clear moved flags");

	property p_br_target;
		(q.fsm == S_Q4 && q.taken) |=> q.pc == $past(q.pc) + br_off($past(q.opnd));
	endproperty
	a_br_target: assert property (p_br_target) else $error("branch target wrong");

	property p_br_cond;
		(q.fsm == S_Q4 && q.op == OP_BR) |-> q.taken == br_cond(q.ir, q.status);
	endproperty
	a_br_cond: assert property (p_br_cond) else $error("branch condition wrong");

	property p_br_taken_len;
		(q.fsm == S_Q4 && q.taken) |=> (q.fsm == S_NOP)[*4] ##1 q.fsm == S_IDLE;
	endproperty
	a_br_taken_len: assert property (p_br_taken_len) else $error("taken branch length");

	property p_quarters;
		(q.fsm == S_Q1) |=> q.fsm == S_Q2 ##1 q.fsm == S_Q3 ##1 q.fsm == S_Q4;
	endproperty
	a_quarters: assert property (p_quarters) else $error("quarter order wrong");

	c_taken: cover property (q.fsm == S_Q4 && q.taken);
	c_add_file: cover property (q.fsm == S_Q4 && q.op == OP_ADD && q.ir[DEST_BIT]);
	c_bclr: cover property (q.fsm == S_Q4 && q.op == OP_BCLR);

endmodule

// ==== cabo_pkg.sv ====
// Shared constants and types for the add, AND, bit-clear and branch execution slice.
package cabo_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// Register byte offsets on the Wishbone slave.
	localparam logic [7:0] REG_CTRL = 8'h00;   // Control: extended set enable.
	localparam logic [7:0] REG_INSTR = 8'h04;  // Instruction word; a write executes it.
	localparam logic [7:0] REG_WACC = 8'h08;   // Working register.
	localparam logic [7:0] REG_STATUS = 8'h0c; // Status flags.
	localparam logic [7:0] REG_BANK = 8'h10;   // Bank select register.
	localparam logic [7:0] REG_PC = 8'h14;     // Program counter.
	localparam logic [7:0] REG_IDX = 8'h18;    // Base for indexed literal offset.
	localparam logic [7:0] REG_MADDR = 8'h1c;  // Data memory window address.
	localparam logic [7:0] REG_MDATA = 8'h20;  // Data memory window data.
	localparam logic [7:0] REG_STATE = 8'h24;  // Sequencer state, read only.

	////////////////////////////////////////////////////////////////////////////////
	// Field positions.
	localparam int FLG_C = 0;    // Carry.
	localparam int FLG_DIG = 1;  // Digit carry.
	localparam int FLG_Z = 2;    // Zero.
	localparam int FLG_OVF = 3;  // Overflow.
	localparam int FLG_N = 4;    // Negative.
	localparam int CTRL_EXT = 0; // Extended instruction set enable.
	localparam int DEST_BIT = 9; // Destination select in the word.
	localparam int ACC_BIT = 8;  // Access bank select in the word.

	////////////////////////////////////////////////////////////////////////////////
	// Reset values.
	localparam logic [7:0] RST_WACC = 8'h00;
	localparam logic [4:0] RST_STATUS = 5'h00;
	localparam logic [3:0] RST_BANK = 4'h0;
	localparam logic [20:0] RST_PC = 21'h000000;
	localparam logic RST_EXT = 1'b0;

	////////////////////////////////////////////////////////////////////////////////
	// Opcode fields and addressing limits.
	localparam logic [5:0] OPC_ADDC = 6'h08;  // Bits 15..10 of add with carry.
	localparam logic [7:0] OPC_ANDL = 8'h0b;  // Bits 15..8 of AND literal.
	localparam logic [5:0] OPC_ANDF = 6'h05;  // Bits 15..10 of AND with file.
	localparam logic [3:0] OPC_BCLR = 4'h9;   // Bits 15..12 of bit clear.
	localparam logic [7:0] OPC_BRC = 8'he2;   // Branch on carry.
	localparam logic [7:0] OPC_BRNC = 8'he3;  // Branch on no carry.
	localparam logic [7:0] OPC_BRN = 8'he6;   // Branch on negative.
	localparam logic [7:0] OPC_BRNN = 8'he7;  // Branch on not negative.
	localparam logic [7:0] IDX_LIMIT = 8'h5f; // Highest indexed offset.
	localparam logic [3:0] ACC_HI_BANK = 4'hf; // Upper half of the access bank.
	localparam logic [20:0] PC_STEP = 21'h000002;
	localparam logic [1:0] NOP_LAST = 2'h3;   // Four quarters of the idle cycle.

	////////////////////////////////////////////////////////////////////////////////
	// Operation classes and sequencer states.
	typedef enum logic [2:0] {
		OP_NONE = 3'h0,
		OP_ADD = 3'h1,
		OP_ANDL = 3'h2,
		OP_ANDF = 3'h3,
		OP_BCLR = 3'h4,
		OP_BR = 3'h5
	} cabo_op_type;

	typedef enum logic [5:0] {
		S_IDLE = 6'h01,
		S_Q1 = 6'h02,
		S_Q2 = 6'h04,
		S_Q3 = 6'h08,
		S_Q4 = 6'h10,
		S_NOP = 6'h20
	} cabo_state_type;

endpackage

// ==== cabo_alu.sv ====
// Data path of the slice: add with carry, AND and single-bit clear with flags.
`timescale 1ns/1ps
module cabo_alu import cabo_pkg::*; (
	input wire cabo_op_type op_i,
	input wire logic [7:0] acc_i,
	input wire logic [7:0] opnd_i,
	input wire logic cin_i,
	input wire logic [2:0] bsel_i,
	output logic [7:0] res_o,
	output logic [4:0] flg_o
);

	logic [8:0] sum;  // Full sum with carry out.
	logic [4:0] nib;  // Low nibble sum for the digit carry.

	////////////////////////////////////////////////////////////////////////////////
	// One combinational path; the caller decides which flags it keeps.
	always_comb begin
		sum = {1'b0, acc_i} + {1'b0, opnd_i} + {8'h00, cin_i};
		nib = {1'b0, acc_i[3:0]} + {1'b0, opnd_i[3:0]} + {4'h0, cin_i};
		res_o = opnd_i;
		case (op_i)
			OP_ADD: begin
				res_o = sum[7:0];
			end
			OP_ANDL, OP_ANDF: begin
				res_o = acc_i & opnd_i;
			end
			OP_BCLR: begin
				res_o = opnd_i & ~(8'h01 << bsel_i);
			end
			default: begin
				res_o = opnd_i;
			end
		endcase
		// Overflow means both inputs share a sign that the result lost.
		flg_o[FLG_C] = sum[8];
		flg_o[FLG_DIG] = nib[4];
		flg_o[FLG_Z] = (res_o == 8'h00);
		flg_o[FLG_OVF] = (acc_i[7] == opnd_i[7]) && (sum[7] != acc_i[7]);
		flg_o[FLG_N] = res_o[7];
	end

endmodule

// ==== cabo_core_tb.sv ====
// Self-checking testbench for the add, AND, bit-clear and branch execution slice.
`timescale 1ns/1ps
module cabo_core_tb import cabo_pkg::*;;

	////////////////////////////////////////////////////////////////////////////////
	// Clock, reset and the Wishbone master's signals.
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic wb_cyc_i = 1'b0;
	logic wb_stb_i = 1'b0;
	logic wb_we_i = 1'b0;
	logic [7:0] wb_adr_i = 8'h00;
	logic [3:0] wb_sel_i = 4'h0;
	logic [31:0] wb_dat_i = 32'h00000000;
	logic [31:0] wb_dat_o;
	logic wb_ack_o;
	logic busy_o;
	int err_count = 0; // Mismatches seen.
	int checked = 0; // Comparisons made.
	logic [39:0] exp_q[$]; // Expected reads as {address, data}, oldest first.
	logic [20:0] pc_exp; // Program counter that the bench predicts.

	// The 4 ns period gives the 250 MHz core clock.
	always #2 clk_i = ~clk_i;

	cabo_core #(.DM_AW(12)) cabo_core_inst (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i),
		.wb_adr_i(wb_adr_i),
		.wb_sel_i(wb_sel_i),
		.wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o),
		.busy_o(busy_o)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Reporting.
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			$display("CHECK FAILED %s expected %h seen %h", name, exp, got);
			err_count++;
		end
	endtask

	// The one place where the run ends.
	task automatic end_sim();
		$display("Counts: %0d comparisons, %0d mismatches", checked, err_count);
		if (err_count == 0 && checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Bus cycles. Ack is looked at on the falling edge so that the rising edge that
	// follows is the one that samples it high; only then is the request released.
	task automatic bus(input logic we, input logic [7:0] adr, input logic [31:0] dat,
			input logic [3:0] sel);
		int n;
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= adr;
		wb_sel_i <= sel;
		wb_dat_i <= dat;
		n = 0;
		do begin
			@(negedge clk_i);
			n++;
			// A held-off request waits at most a taken branch plus the access itself.
			if (n > 40) begin
				chk("ack wait", 32'h1, 32'h0);
				end_sim();
			end
		end while (wb_ack_o !== 1'b1);
		@(posedge clk_i);
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
		bus(1'b1, adr, dat, 4'hf);
	endtask

	// The expectation is noted before the request; the monitor compares it.
	task automatic rd(input logic [7:0] adr, input logic [31:0] exp);
		exp_q.push_back({adr, exp});
		bus(1'b0, adr, 32'h00000000, 4'hf);
	endtask

	// Runs one instruction and counts the cycles that busy stands high.
	task automatic exec(input logic [15:0] instr, input int ncyc);
		int n;
		wr(REG_INSTR, {16'h0000, instr});
		n = 1;
		forever begin
			@(negedge clk_i);
			if (busy_o !== 1'b1) break;
			n++;
			// A run that never ends counts as a mismatch and closes the run.
			if (n > 20) begin
				chk("busy wait", 32'h0, 32'h1);
				end_sim();
			end
		end
		chk("busy cycles", ncyc, n);
	endtask

	// Read monitor: takes the oldest note whenever read data is acknowledged.
	always @(posedge clk_i) begin
		if (wb_ack_o === 1'b1 && wb_cyc_i && !wb_we_i) begin
			if (exp_q.size() == 0) begin
				chk("unexpected read", 32'h0, 32'h1);
			end else begin
				chk($sformatf("read at %h", exp_q[0][39:32]), exp_q[0][31:0], wb_dat_o);
				void'(exp_q.pop_front());
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Main sequence.
	initial begin
		logic d, a;
		logic [2:0] b;
		logic [7:0] f, w, m, res, n8;
		logic [4:0] st, nst, lo_sum;
		logic [3:0] bank;
		logic [11:0] addr;
		logic [8:0] sum;
		logic [15:0] instr;
		logic [7:0] brop[4];
		int op, flg;
		logic taken;
		brop = '{OPC_BRC, OPC_BRNC, OPC_BRN, OPC_BRNN};
		void'($urandom(32'h5f7a));
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		// Reset state, an unmapped offset and byte-lane gating.
		rd(REG_WACC, 32'h0);
		rd(REG_STATUS, 32'h0);
		rd(REG_PC, 32'h0);
		wr(8'h28, 32'h000000ff);
		rd(8'h28, 32'h0);
		wr(REG_WACC, 32'h55);
		bus(1'b1, REG_WACC, 32'haa, 4'he);
		rd(REG_WACC, 32'h55);
		pc_exp = 21'h0;
		// Random mix of the data instructions, with corner operands in two rounds.
		for (int i = 0; i < 24; i++) begin
			op = i % 4;
			{d, a, b, f, w, m} = 29'($urandom);
			{st, bank} = 9'($urandom);
			if (i == 0) begin
				{w, m, st} = {8'h80, 8'h80, 5'h00};
			end
			if (i == 5) begin
				w = 8'h00;
			end
			addr = a ? {bank, f} : (f <= IDX_LIMIT ? {4'h0, f} : {ACC_HI_BANK, f});
			wr(REG_WACC, {24'h0, w});
			wr(REG_STATUS, {27'h0, st});
			wr(REG_BANK, {28'h0, bank});
			wr(REG_MADDR, {20'h0, addr});
			wr(REG_MDATA, {24'h0, m});
			nst = st;
			case (op)
				0: begin
					sum = {1'b0, w} + {1'b0, m} + 9'(st[FLG_C]);
					lo_sum = {1'b0, w[3:0]} + {1'b0, m[3:0]} + 5'(st[FLG_C]);
					res = sum[7:0];
					nst[FLG_C] = sum[8];
					nst[FLG_DIG] = lo_sum[4];
					nst[FLG_OVF] = (w[7] == m[7]) && (res[7] != w[7]);
					instr = {OPC_ADDC, d, a, f};
				end
				1: begin
					res = w & f;
					d = 1'b0;
					instr = {OPC_ANDL, f};
				end
				2: begin
					res = w & m;
					instr = {OPC_ANDF, d, a, f};
				end
				default: begin
					res = m & ~(8'h01 << b);
					d = 1'b1;
					instr = {OPC_BCLR, b, a, f};
				end
			endcase
			// Bit clear leaves every flag alone; the others set N and Z.
			if (op != 3) begin
				nst[FLG_N] = res[7];
				nst[FLG_Z] = (res == 8'h00);
			end
			exec(instr, 4);
			pc_exp = pc_exp + PC_STEP;
			rd(REG_WACC, {24'h0, d ? w : res});
			rd(REG_STATUS, {27'h0, nst});
			rd(REG_MDATA, {24'h0, d ? res : m});
			rd(REG_PC, {11'h0, pc_exp});
		end
		// Extended set: offsets up to the limit are indexed, the next one is not.
		wr(REG_CTRL, 32'h1);
		wr(REG_IDX, 32'h120);
		wr(REG_WACC, 32'h0f);
		for (int i = 0; i < 2; i++) begin
			f = (i == 0) ? 8'h5f : 8'h60;
			addr = (i == 0) ? 12'h120 + 12'(f) : {ACC_HI_BANK, f};
			wr(REG_MADDR, {20'h0, addr});
			wr(REG_MDATA, 32'hff);
			exec({OPC_ANDF, 1'b1, 1'b0, f}, 4);
			rd(REG_MDATA, 32'h0f);
		end
		wr(REG_CTRL, 32'h0);
		// Every branch with its flag set and clear; carry branches at the top end of the offset range, negative ones at the bottom.
		for (int k = 0; k < 8; k++) begin
			op = k / 2;
			flg = (op < 2) ? FLG_C : FLG_N;
			n8 = (k < 4) ? 8'h7f : 8'h80;
			st = 5'($urandom);
			st[flg] = k[0];
			taken = (k[0] == ~op[0]);
			wr(REG_STATUS, {27'h0, st});
			wr(REG_PC, 32'h1000);
			pc_exp = 21'h1002 + (taken ? {{12{n8[7]}}, n8, 1'b0} : 21'h0);
			exec({brop[op], n8}, taken ? 8 : 4);
			rd(REG_PC, {11'h0, pc_exp});
			rd(REG_STATUS, {27'h0, st});
			// Back at idle with busy low; the taken bit tells which path ran.
			rd(REG_STATE, {24'h0, taken, 1'b0, S_IDLE});
		end
		// A second reset in mid-run brings the state back.
		@(posedge clk_i);
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		rd(REG_WACC, 32'h0);
		rd(REG_PC, 32'h0);
		repeat (3) @(posedge clk_i);
		chk("pending reads", 32'h0, exp_q.size());
		end_sim();
	end

endmodule
